// ---- src/gpio_pkg.sv ----
package gpio_pkg;

   // ==========================================================
   // Geometry
   localparam int NPORT = 6;
   localparam int NBIT  = 8;

   // ==========================================================
   // Register map, byte addresses on the plain register port
   localparam logic [7:0] DATA_OFS [NPORT] =
      '{8'h00, 8'h03, 8'h06, 8'h09, 8'h0C, 8'h0F};
   localparam logic [7:0] DIR_OFS  [NPORT] =
      '{8'h01, 8'h04, 8'h07, 8'h0A, 8'h0D, 8'h10};
   // Ports without an option register carry an address never decoded
   localparam logic [7:0] OPT_OFS  [NPORT] =
      '{8'h02, 8'hFF, 8'h08, 8'h0B, 8'h0E, 8'hFF};
   localparam logic [7:0] MISC_OFS = 8'h11;  // Sense fields, clock out
   localparam logic [7:0] STS_OFS  = 8'h12;  // Sticky event status
   localparam logic [7:0] MSK_OFS  = 8'h13;  // Event mask

   // ==========================================================
   // Misc register field positions
   localparam int SENSE0_LSB = 6;  // Bits 7:6, group zero
   localparam int MCO_BIT    = 5;  // Clock out enable
   localparam int SENSE1_LSB = 3;  // Bits 4:3, group one

   // ==========================================================
   // Per-port capabilities (bit p = port p, A..F)
   localparam logic [NPORT-1:0] HAS_OPT = 6'h1D;  // A, C, D, E
   localparam int GRP0_PORT = 0;                   // Port A
   localparam int GRP1_PORT = 3;                   // Port D
   localparam int PULLUP_PORT = 4;                 // Port E pin 5
   localparam int PULLUP_BIT  = 5;
   // Pins wired push-pull or open drain regardless of option
   localparam logic [NBIT-1:0] FORCE_PP [NPORT] =
      '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h8C};
   localparam logic [NBIT-1:0] FORCE_OD [NPORT] =
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h73};
   // Pin that carries the CPU clock when clock out is enabled
   localparam int CLKOUT_PORT = 5;
   localparam int CLKOUT_BIT  = 3;

   // ==========================================================
   // Reset value and sensitivity encodings
   localparam logic [7:0] REG_RESET = 8'h00;
   typedef enum logic [1:0] {
      SENSE_FALL_LOW = 2'h0,
      SENSE_RISE     = 2'h1,
      SENSE_FALL     = 2'h2,
      SENSE_BOTH     = 2'h3
   } sense_e;

   // ==========================================================
   // Carriers
   typedef logic [NPORT-1:0][NBIT-1:0] port_arr_t;
   typedef struct packed {
      port_arr_t in;   // Pad levels from outside
      port_arr_t out;  // Level driven when enabled
      port_arr_t oe;   // High while driving
   } pins_s;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_s;

endpackage

// ---- src/gpio_ports_with_irq_sense.sv ----
// How it works
// - Port B: direction bit alone, input or push-pull
// - Data latch written even while pin inputs
// - Data read: latch if output, pin if input
// - Direction zero input, one output
// - Input option set enables interrupt capability on ports A and D
// - Output option clear open drain, set push-pull; port C pins stay push-pull either way
// - Ports without option use direction only
// - Port F output stages follow per-pin table
// - All port registers reset to zero
// - Port registers at consecutive byte addresses
// - Group zero sensitivity in misc bits 7:6
// - Group one sensitivity in misc bits 4:3
// - Sense writes only at interrupt level three
// - Clock out bit drives CPU clock out
// - Enabled group pins combined as AND
// - Pending cleared by vector fetch, sense change
// - Alternate function overrides port programming
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_with_irq_sense
   import gpio_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   // Register port
   input  wire bus_req_s   bus_i,
   output logic [7:0]      rdata_o,
   // CPU condition code mask bits, irq_mask_high and irq_mask_low
   input  wire logic [1:0] cc_irq_mask_i,
   // External interrupt requests and vector fetch acknowledge
   output logic [1:0]      ext_irq_req_o,
   input  wire logic [1:0] ext_irq_ack_i,
   // Alternate functions from on-chip peripherals
   input  wire port_arr_t  alt_en_i,
   input  wire port_arr_t  alt_out_i,
   // Pins
   input  wire port_arr_t  pin_i,
   output port_arr_t       pin_o,
   output port_arr_t       pin_oe_o,
   output logic            pullup_en_o,
   // Event interrupt
   output logic            irq_o
);

   // ==========================================================
   // Reset release synchroniser
   logic rst_s1_q;  // First stage, read only by second
   logic rst_n_q;   // Released reset used everywhere

   // Asynchronous assert, synchronous release
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ==========================================================
   // State
   typedef struct packed {
      port_arr_t  data;     // Data latches
      port_arr_t  dir;      // Direction bits
      port_arr_t  opt;      // Option bits
      port_arr_t  syn1;     // Pin sync stage one
      port_arr_t  syn2;     // Pin sync stage two
      logic [1:0] sense0;   // Group zero sensitivity
      logic [1:0] sense1;   // Group one sensitivity
      logic       cpu_clock_out_enable;      // Clock out enable
      logic [1:0] prev;     // Last combined group levels
      logic [1:0] pend;     // Pending request latches
      logic [1:0] sts;      // Sticky event status
      logic [1:0] msk;      // Event mask
      logic [7:0] rdata;    // Read data, valid one cycle later
   } state_s;

   state_s q;  // Registered state
   state_s d;  // Next state

   // Group combine helpers
   logic [1:0]      grp_any;  // Any pin enabled in group
   logic [1:0]      grp_lvl;  // Combined group level
   logic [1:0]      grp_set;  // Detected event this cycle
   logic [1:0][1:0] grp_sns;  // Sensitivity per group
   logic            sense_ok; // Sense fields writable

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [7:0]      en0;
      logic [7:0]      en1;
      logic [1:0]      fall;
      logic [1:0]      rise;
      logic [1:0]      sns_chg;
      logic [1:0]      wr_s0;
      logic [1:0]      wr_s1;
      en0     = 8'h00;
      en1     = 8'h00;
      fall    = 2'h0;
      rise    = 2'h0;
      sns_chg = 2'h0;
      wr_s0   = 2'h0;
      wr_s1   = 2'h0;
      d       = q;
      // No event unless a sense mode below detects one
      grp_set = 2'h0;

      // Two flops ahead of any pin logic
      d.syn1 = pin_i;
      d.syn2 = q.syn1;

      // Input with option set is an interrupt source
      en0 = ~q.dir[GRP0_PORT] & q.opt[GRP0_PORT];
      en1 = ~q.dir[GRP1_PORT] & q.opt[GRP1_PORT];
      grp_any = {|en1, |en0};
      // Disabled pins read as high, so a low pin masks others
      grp_lvl = {&(q.syn2[GRP1_PORT] | ~en1),
                 &(q.syn2[GRP0_PORT] | ~en0)};
      grp_sns = {q.sense1, q.sense0};
      fall    = q.prev & ~grp_lvl;
      rise    = ~q.prev & grp_lvl;
      for (int g = 0; g < 2; g++) begin
         unique case (sense_e'(grp_sns[g]))
            SENSE_FALL_LOW: grp_set[g] = grp_any[g] & ~grp_lvl[g];
            SENSE_RISE:     grp_set[g] = grp_any[g] & rise[g];
            SENSE_FALL:     grp_set[g] = grp_any[g] & fall[g];
            SENSE_BOTH:     grp_set[g] = grp_any[g] & (rise[g] | fall[g]);
         endcase
      end
      d.prev = grp_lvl;

      // Register writes
      sense_ok = &cc_irq_mask_i;
      if (bus_i.wr) begin
         for (int p = 0; p < NPORT; p++) begin
            // Latch stored whatever the direction
            if (bus_i.addr == DATA_OFS[p]) begin
               d.data[p] = bus_i.wdata;
            end
            if (bus_i.addr == DIR_OFS[p]) begin
               d.dir[p] = bus_i.wdata;
            end
            // Absent option registers stay zero
            if (HAS_OPT[p] && bus_i.addr == OPT_OFS[p]) begin
               d.opt[p] = bus_i.wdata;
            end
         end
         if (bus_i.addr == MISC_OFS) begin
            d.cpu_clock_out_enable = bus_i.wdata[MCO_BIT];
            // Sense fields locked unless both mask bits set
            if (sense_ok) begin
               wr_s0    = bus_i.wdata[SENSE0_LSB +: 2];
               wr_s1    = bus_i.wdata[SENSE1_LSB +: 2];
               d.sense0 = wr_s0;
               d.sense1 = wr_s1;
               sns_chg  = {wr_s1 != q.sense1, wr_s0 != q.sense0};
            end
         end
         if (bus_i.addr == MSK_OFS) begin
            d.msk = bus_i.wdata[1:0];
         end
      end

      // Pending latch: set wins over fetch or sense clear
      d.pend = (q.pend & ~(ext_irq_ack_i | sns_chg)) | grp_set;

      // Sticky status, write one to clear, set wins
      if (bus_i.wr && bus_i.addr == STS_OFS) begin
         d.sts = (q.sts & ~bus_i.wdata[1:0]) | grp_set;
      end else begin
         d.sts = q.sts | grp_set;
      end

      // Read data, zero for unmapped addresses
      d.rdata = 8'h00;
      if (bus_i.rd) begin
         for (int p = 0; p < NPORT; p++) begin
            if (bus_i.addr == DATA_OFS[p]) begin
               d.rdata = (q.data[p] & q.dir[p]) |
                         (q.syn2[p] & ~q.dir[p]);
            end
            if (bus_i.addr == DIR_OFS[p]) begin
               d.rdata = q.dir[p];
            end
            if (HAS_OPT[p] && bus_i.addr == OPT_OFS[p]) begin
               d.rdata = q.opt[p];
            end
         end
         unique case (bus_i.addr)
            MISC_OFS: d.rdata = {q.sense0, q.cpu_clock_out_enable, q.sense1, 3'h0};
            STS_OFS:  d.rdata = {6'h00, q.sts};
            MSK_OFS:  d.rdata = {6'h00, q.msk};
            default:  d.rdata = d.rdata;
         endcase
      end
   end

   // ==========================================================
   // State register, all zero at reset
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Pin drivers, one per pin
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      for (genvar b = 0; b < NBIT; b++) begin : g_bit
         logic push_pull;  // Output stage mode
         // Option bit picks push-pull; fixed pins ignore it
         assign push_pull = FORCE_PP[p][b] |
                            (HAS_OPT[p] & q.opt[p][b] &
                             ~FORCE_OD[p][b]);
         always_comb begin
            if (p == CLKOUT_PORT && b == CLKOUT_BIT && q.cpu_clock_out_enable) begin
               // Clock routed straight out; glitch-free since the
               // enable changes only after a rising edge
               pin_oe_o[p][b] = 1'b1;
               pin_o[p][b]    = core_clk_i;
            end else if (alt_en_i[p][b]) begin
               // Peripheral owns the pin
               pin_oe_o[p][b] = 1'b1;
               pin_o[p][b]    = alt_out_i[p][b];
            end else if (q.dir[p][b]) begin
               if (push_pull) begin
                  pin_oe_o[p][b] = 1'b1;
                  pin_o[p][b]    = q.data[p][b];
               end else begin
                  // High side off: release instead of driving one
                  pin_oe_o[p][b] = ~q.data[p][b];
                  pin_o[p][b]    = 1'b0;
               end
            end else begin
               // Floating input
               pin_oe_o[p][b] = 1'b0;
               pin_o[p][b]    = 1'b0;
            end
         end
      end
   end

   // Port E pin 5 input option selects the pull-up, not an interrupt
   assign pullup_en_o = ~q.dir[PULLUP_PORT][PULLUP_BIT] &
                        q.opt[PULLUP_PORT][PULLUP_BIT];

   // ==========================================================
   // Outputs
   assign rdata_o       = q.rdata;
   assign ext_irq_req_o = q.pend;
   assign irq_o         = |(q.sts & q.msk);

   // ==========================================================
   // Checks
   // Pin stage and register port checks
   AST_PORTB_FLOAT: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (!q.dir[1][0] && !alt_en_i[1][0])
      |-> !pin_oe_o[1][0]) else $error("input pin driven");

   AST_PORTB_PP: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (q.dir[1][2] && !alt_en_i[1][2])
      |-> (pin_oe_o[1][2] && pin_o[1][2] == q.data[1][2]))
      else $error("port B not push-pull");

   AST_OPEN_DRAIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q)
      (q.dir[0][1] && !q.opt[0][1] && !alt_en_i[0][1])
      |-> (!pin_o[0][1] && pin_oe_o[0][1] == !q.data[0][1]))
      else $error("open drain drives high");

   AST_WR_STORE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (bus_i.wr && bus_i.addr == DATA_OFS[2])
      |=> q.data[2] == $past(bus_i.wdata))
      else $error("latch write lost");

   AST_RD_MIX: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (bus_i.rd && bus_i.addr == DATA_OFS[0])
      |=> rdata_o == (($past(q.data[0]) & $past(q.dir[0])) |
                      ($past(q.syn2[0]) & ~$past(q.dir[0]))))
      else $error("data read wrong");

   // Absent option registers must never take a write
   AST_OPT_ABSENT: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q)
      q.opt[1] == REG_RESET && q.opt[5] == REG_RESET)
      else $error("absent option register written");

   // Only pin 5 of port E asks for the pull-up
   AST_PULLUP_OUT: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (q.opt[PULLUP_PORT][4] &&
      !q.opt[PULLUP_PORT][PULLUP_BIT]) |-> !pullup_en_o)
      else $error("pull-up from wrong pin");

   AST_ALT_PRIO: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) alt_en_i[0][7]
      |-> (pin_oe_o[0][7] && pin_o[0][7] == alt_out_i[0][7]))
      else $error("alternate not in control");

   AST_MCO_PIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) q.cpu_clock_out_enable |-> pin_oe_o[CLKOUT_PORT][CLKOUT_BIT])
      else $error("clock out not driven");

   // Interrupt detection checks
   AST_SENSE_LOCK: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (bus_i.wr && bus_i.addr == MISC_OFS &&
      cc_irq_mask_i != 2'h3) |=> $stable(q.sense0) && $stable(q.sense1))
      else $error("sense written below level 3");

   AST_ACK_CLR: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (ext_irq_ack_i[0] && !grp_set[0])
      |=> !ext_irq_req_o[0]) else $error("fetch left pending");

   AST_SENSE_CLR: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (bus_i.wr && bus_i.addr == MISC_OFS &&
      sense_ok && bus_i.wdata[SENSE0_LSB +: 2] != q.sense0 && !grp_set[0])
      |=> !ext_irq_req_o[0]) else $error("sense change kept pending");

   AST_LOW_LEVEL: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (q.sense0 == 2'h0 && grp_any[0] &&
      !grp_lvl[0]) |=> ext_irq_req_o[0] && q.sts[0])
      else $error("low level missed");

   AST_FALL_GRP1: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) (q.sense1 == 2'h2 && grp_any[1] &&
      q.prev[1] && !grp_lvl[1]) |=> ext_irq_req_o[1] && q.sts[1])
      else $error("group one fall missed");

   // Second stage must only ever copy the first
   AST_SYNC_CHAIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_q) q.syn2 == $past(q.syn1))
      else $error("pin sync skipped a stage");

   // ==========================================================
   // Coverage of the main scenarios
   COV_GRP0_EVENT: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_q) grp_set[0] ##1 ext_irq_ack_i[0]);
   COV_GRP1_RISE: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_q) q.sense1 == 2'h1 && grp_set[1]);
   COV_IRQ_OUT: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_q) irq_o ##1 !irq_o);
   COV_REQ_DROP: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_q) ext_irq_req_o[0] ##1 !ext_irq_req_o[0]);
   COV_ALT_PIN: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_q) alt_en_i[2][0] && pin_oe_o[2][0]);

endmodule
`default_nettype wire

// ---- testbench/ext_circuit.sv ----
`timescale 1ns/100ps
`default_nettype none
module ext_circuit
   import gpio_pkg::*;
(
   // Pads as the block drives them
   input  wire port_arr_t pin_o_i,
   input  wire port_arr_t pin_oe_i,
   // Level the outside world puts on released pads
   input  wire port_arr_t ext_lvl_i,
   // Resolved pad level
   output port_arr_t      pad_o
);
   // ==========================================================
   // Pad resolution
   // Released pads never keep the block's last level, so a stuck
   // enable shows up as the outside level instead
   always_comb begin
      pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_lvl_i);
   end
endmodule
`default_nettype wire

// ---- testbench/gpio_ports_with_irq_sense_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_with_irq_sense_bench
   import gpio_pkg::*;
;
   // ==========================================================
   // Stimulus and observed signals
   logic       core_clk;  // 125 MHz
   logic       rstn;      // Active low
   bus_req_s   bus;       // Register port request
   logic [7:0] rdata;     // Read data
   logic [1:0] cc_mask;   // Condition code mask bits
   logic [1:0] irq_req;   // Pending group requests
   logic [1:0] ack;       // Vector fetch pulses
   port_arr_t  alt_en;    // Alternate function enables
   port_arr_t  alt_out;   // Alternate function levels
   port_arr_t  pad;       // Resolved pads
   port_arr_t  pin_out;   // Block drive level
   port_arr_t  pin_oe;    // Block drive enable
   port_arr_t  ext_lvl;   // Outside level on released pads
   logic       pullup_en; // Pull-up request
   logic       irq;       // Event interrupt
   int         failures;  // Mismatch count
   int         n_tests;   // Comparison count
   int         cyc;       // Cycle count for the hang guard

   // ==========================================================
   // Block and outside circuitry
   gpio_ports_with_irq_sense u_dut (
      .core_clk_i   (core_clk),
      .rstn_i       (rstn),
      .bus_i        (bus),
      .rdata_o      (rdata),
      .cc_irq_mask_i(cc_mask),
      .ext_irq_req_o(irq_req),
      .ext_irq_ack_i(ack),
      .alt_en_i     (alt_en),
      .alt_out_i    (alt_out),
      .pin_i        (pad),
      .pin_o        (pin_out),
      .pin_oe_o     (pin_oe),
      .pullup_en_o  (pullup_en),
      .irq_o        (irq)
   );
   ext_circuit u_ext (
      .pin_o_i  (pin_out),
      .pin_oe_i (pin_oe),
      .ext_lvl_i(ext_lvl),
      .pad_o    (pad)
   );

   // ==========================================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Whole run is well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end

   // ==========================================================
   // Helpers
   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // One-cycle write strobe; next access waits one edge more
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= d;
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1;
      chk(exp, rdata);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      bus = '0;
      cc_mask = 2'h0;
      ack = 2'h0;
      alt_en = '0;
      alt_out = '0;
      ext_lvl = '0;
      failures = 0;
      n_tests = 0;
      cyc = 0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge core_clk);
      // Every location reads zero out of reset
      for (int a = 0; a < 20; a++) rd_chk(8'(a), 8'h00);
      for (int p = 0; p < NPORT; p++) chk(8'h00, pin_oe[p]);
      // Map walk with distinct values, unused hole stays empty
      for (int p = 0; p < NPORT; p++) begin
         wr(DIR_OFS[p], 8'(p + 8'h31));
         if (HAS_OPT[p]) wr(OPT_OFS[p], 8'(p + 8'h41));
      end
      wr(8'h05, 8'hFF);
      for (int p = 0; p < NPORT; p++) begin
         rd_chk(DIR_OFS[p], 8'(p + 8'h31));
         if (HAS_OPT[p]) rd_chk(OPT_OFS[p], 8'(p + 8'h41));
         wr(DIR_OFS[p], 8'h00);
         if (HAS_OPT[p]) wr(OPT_OFS[p], 8'h00);
      end
      rd_chk(8'h05, 8'h00);
      // Port B latch written while input, then half turned round
      ext_lvl[1] <= 8'h55;
      wr(DATA_OFS[1], 8'hAA);
      wt(0);
      chk(8'h00, pin_oe[1]);
      rd_chk(DATA_OFS[1], 8'h55);
      wr(DIR_OFS[1], 8'h0F);
      wt(0);
      chk(8'h0F, pin_oe[1]);
      chk(8'h0A, pin_out[1] & 8'h0F);
      rd_chk(DATA_OFS[1], 8'h5A);
      // Read data stand one cycle only
      wt(1);
      chk(8'h00, rdata);
      // Port A open drain, then push-pull
      wr(DATA_OFS[0], 8'h0F);
      wr(DIR_OFS[0], 8'hFF);
      wt(0);
      chk(8'hF0, pin_oe[0]);
      chk(8'h00, pin_out[0] & pin_oe[0]);
      wr(OPT_OFS[0], 8'hFF);
      wt(0);
      chk(8'hFF, pin_oe[0]);
      chk(8'h0F, pin_out[0]);
      wr(DIR_OFS[0], 8'h00);
      // Port E: only pin 5 reacts to its option bit in input mode
      wr(OPT_OFS[4], 8'h20);
      wt(0);
      chk(8'h01, 8'(pullup_en));
      wr(OPT_OFS[4], 8'h10);
      wt(0);
      chk(8'h00, 8'(pullup_en));
      // Alternate function wins over an input direction
      alt_en[2][0] <= 1'b1;
      alt_out[2][0] <= 1'b1;
      wt(1);
      chk(8'h01, pin_oe[2] & pin_out[2] & 8'h01);
      alt_en[2][0] <= 1'b0;
      // Port F keeps its fixed output stages, no option register
      wr(DATA_OFS[5], 8'hFF);
      wr(DIR_OFS[5], 8'hFF);
      wt(0);
      chk(8'h8C, pin_oe[5]);
      wr(DIR_OFS[5], 8'h00);
      // Sense fields locked below level 3, clock out always taken
      wr(MISC_OFS, 8'hF8);
      wt(0);
      chk(8'h08, pin_oe[5] & 8'h08);
      // Clock is high just after its rising edge
      chk(8'h08, pin_out[5] & 8'h08);
      rd_chk(MISC_OFS, 8'h20);
      cc_mask <= 2'h3;
      wr(MISC_OFS, 8'hD8);
      wt(0);
      chk(8'h00, pin_oe[5] & 8'h08);
      rd_chk(MISC_OFS, 8'hD8);
      // Group zero on pins A1:A0, falling edge, unmasked
      ext_lvl[0] <= 8'hFF;
      ext_lvl[3] <= 8'hFF;
      wr(OPT_OFS[0], 8'h03);
      wr(MISC_OFS, 8'h80);
      wr(MSK_OFS, 8'h03);
      wr(STS_OFS, 8'h03);
      ext_lvl[0][1] <= 1'b0;
      wt(6);
      chk(8'h01, 8'(irq_req));
      chk(8'h01, 8'(irq));
      rd_chk(STS_OFS, 8'h01);
      @(posedge core_clk);
      ack <= 2'h1;
      @(posedge core_clk);
      ack <= 2'h0;
      wt(0);
      chk(8'h00, 8'(irq_req));
      wr(STS_OFS, 8'h01);
      wt(0);
      chk(8'h00, 8'(irq));
      // A low pin hides the other one's edge
      ext_lvl[0][0] <= 1'b0;
      wt(6);
      chk(8'h00, 8'(irq_req));
      // Rising group ignored in falling mode; masked event
      ext_lvl[0] <= 8'hFF;
      wt(6);
      chk(8'h00, 8'(irq_req));
      wr(MSK_OFS, 8'h00);
      ext_lvl[0][0] <= 1'b0;
      wt(6);
      chk(8'h01, 8'(irq_req));
      chk(8'h00, 8'(irq));
      // Sense change drops the pending request
      wr(MISC_OFS, 8'h40);
      wt(0);
      chk(8'h00, 8'(irq_req));
      wr(MSK_OFS, 8'h03);
      wt(0);
      chk(8'h01, 8'(irq));
      wr(STS_OFS, 8'h03);
      ext_lvl[0][0] <= 1'b1;
      wt(6);
      chk(8'h01, 8'(irq_req));
      // Group one on pin D0, falling, then low level
      wr(OPT_OFS[3], 8'h01);
      wr(MISC_OFS, 8'h50);
      ext_lvl[3][0] <= 1'b0;
      wt(6);
      chk(8'h03, 8'(irq_req));
      wr(MISC_OFS, 8'h40);
      wt(4);
      chk(8'h03, 8'(irq_req));
      summarize();
   end
endmodule
`default_nettype wire
